// ===== rtl/gsri_top.sv
// gsri_top: serial register access of an autonomous rate sensor
// assumes: master drives mode 3 frames; flash answers in the same cycle as its address
`timescale 1ns/1ps
`include "gsri_regs.svh"

module gsri_top (
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	input  wire logic        spi_sclk,
	input  wire logic        spi_cs_n,
	input  wire logic        spi_din,
	output logic             spi_dout,
	output logic             spi_dout_oe,
	input  wire logic [15:0] rate_in,
	input  wire logic        rate_valid,
	input  wire logic [15:0] flash_rdata,
	output logic [1:0]       flash_addr,
	output logic [15:0]      flash_wdata,
	output logic             flash_we,
	output logic             config_ready,
	output logic             bias_null_start,
	output logic [15:0]      gyro_offset,
	output logic [15:0]      gyro_scale,
	output logic [15:0]      sample_period,
	output logic [1:0]       dio_out,
	output logic [1:0]       dio_oe
);

	gsri_pkg::gsri_core_type st;
	gsri_pkg::gsri_core_type next_st;
	gsri_frame_if            frame ();

	logic [15:0] word;
	logic [6:0]  addr;
	logic [6:0]  base;
	logic        cs_fall;
	logic        sclk_fall;
	logic        frame_new;
	logic        dr_level;
	logic [2:0]  slot;

	////////////////////////////////////////////////////////////////////////
	// link clock domain: receiver only, everything else runs on ref_clk
	gsri_link_rx u_link (
		.spi_sclk (spi_sclk),
		.spi_cs_n (spi_cs_n),
		.spi_din  (spi_din),
		.link_rst (sys_rst),
		.frame    (frame)
	);

	////////////////////////////////////////////////////////////////////////
	// slot of a flash-backed register, or none
	function automatic logic [2:0] slot_of(input logic [6:0] a);
		logic [2:0] s;
		s = 3'h0;
		unique case (a)
			`GSRI_ADDR_GYRO_OFF: s = {1'b1, `GSRI_SLOT_OFF};
			`GSRI_ADDR_GYRO_SCL: s = {1'b1, `GSRI_SLOT_SCL};
			`GSRI_ADDR_MISC:     s = {1'b1, `GSRI_SLOT_MISC};
			`GSRI_ADDR_SMPL:     s = {1'b1, `GSRI_SLOT_SMPL};
			default:             s = 3'h0;
		endcase
		return s;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// replace one byte of a word
	function automatic logic [15:0] put_byte(
		input logic [15:0] old,
		input logic        upper,
		input logic [7:0]  data
	);
		logic [15:0] w;
		w = old;
		if (upper) begin
			w[15:8] = data;
		end else begin
			w[7:0] = data;
		end
		return w;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// frame fields and edges seen after synchronisation
	always_comb begin
		word = frame.word;
		addr = word[`GSRI_ADR_HI:`GSRI_ADR_LO];
		base = addr & `GSRI_ADDR_WORD;
		// slot decode held in a net, a call result cannot be indexed
		slot = slot_of(base);
		// only the second and third stages are looked at
		cs_fall   = st.cs_sync[2] & ~st.cs_sync[1];
		sclk_fall = st.sclk_sync[2] & ~st.sclk_sync[1];
		// word is quasi-static: it is read only once done has crossed
		frame_new = st.done_sync[1] & ~st.done_sync[2];
		if (st.cfg[`GSRI_SLOT_MISC][`GSRI_DR_POL]) begin
			dr_level = st.drdy;
		end else begin
			dr_level = ~st.drdy;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// next state of the core
	always_comb begin
		next_st            = st;
		next_st.flash_we   = 1'b0;
		next_st.null_start = 1'b0;

		// pins and the done level each pass two flops first
		next_st.cs_sync   = {st.cs_sync[1:0], spi_cs_n};
		next_st.sclk_sync = {st.sclk_sync[1:0], spi_sclk};
		next_st.done_sync = {st.done_sync[1:0], frame.done};

		// output shifter, about three ref cycles behind the pin edges
		if (st.cs_sync[1]) begin
			next_st.dout_oe = 1'b0;
			next_st.dout    = 1'b0;
		end else if (cs_fall) begin
			next_st.dout_oe   = 1'b1;
			next_st.tx        = st.resp;
			next_st.dout      = st.resp[15];
			next_st.fall_seen = 1'b0;
		end else if (sclk_fall) begin
			// mode 3 has a falling edge before the first rise; msb must stay
			if (!st.fall_seen) begin
				next_st.fall_seen = 1'b1;
			end else begin
				next_st.tx   = {st.tx[14:0], 1'b0};
				next_st.dout = st.tx[14];
			end
		end

		// a decoded frame; the first stage of each chain is never read here
		if (frame_new) begin
			if (!word[`GSRI_WR_BIT]) begin
				// data byte of a read unused
				unique case (base)
					`GSRI_ADDR_RATE: begin
						next_st.resp = st.rate;
						next_st.drdy = 1'b0;
					end
					`GSRI_ADDR_GYRO_OFF: next_st.resp = st.cfg[`GSRI_SLOT_OFF];
					`GSRI_ADDR_GYRO_SCL: next_st.resp = st.cfg[`GSRI_SLOT_SCL];
					`GSRI_ADDR_MISC:     next_st.resp = st.cfg[`GSRI_SLOT_MISC];
					`GSRI_ADDR_SMPL:     next_st.resp = st.cfg[`GSRI_SLOT_SMPL];
					default:             next_st.resp = 16'h0000;
				endcase
			end else if (st.state == gsri_pkg::GSRI_RUN) begin
				// upper or lower byte by address
				if (slot[2]) begin
					next_st.cfg[slot[1:0]] =
						put_byte(st.cfg[slot[1:0]], addr[0], word[7:0]);
				end
				if (addr == `GSRI_ADDR_GLOB) begin
					next_st.null_start = word[`GSRI_CMD_NULL];
					if (word[`GSRI_CMD_SAVE]) begin
						next_st.state = gsri_pkg::GSRI_SAVE;
						next_st.idx   = 2'h0;
					end
				end
			end
		end

		// rate loads without host action
		// a new sample in the same cycle as a rate read keeps data ready set
		if (rate_valid && st.cfg_ready) begin
			next_st.rate = rate_in;
			next_st.drdy = 1'b1;
		end

		if (st.cfg[`GSRI_SLOT_MISC][`GSRI_DR_EN]) begin
			if (st.cfg[`GSRI_SLOT_MISC][`GSRI_DR_SEL]) begin
				next_st.dio_oe  = 2'b10;
				next_st.dio_out = {dr_level, 1'b0};
			end else begin
				next_st.dio_oe  = 2'b01;
				next_st.dio_out = {1'b0, dr_level};
			end
		end else begin
			next_st.dio_oe  = 2'b00;
			next_st.dio_out = 2'b00;
		end

		// configuration sequencer
		unique case (st.state)
			gsri_pkg::GSRI_LOAD: begin
				if (!st.phase) begin
					next_st.flash_addr = st.idx;
					next_st.phase      = 1'b1;
				end else begin
					next_st.cfg[st.idx] = flash_rdata;
					next_st.phase       = 1'b0;
					if (st.idx == `GSRI_SLOT_LAST) begin
						next_st.state     = gsri_pkg::GSRI_RUN;
						next_st.cfg_ready = 1'b1;
					end else begin
						next_st.idx = st.idx + 2'h1;
					end
				end
			end
			gsri_pkg::GSRI_RUN: begin
				next_st.phase = 1'b0;
			end
			gsri_pkg::GSRI_SAVE: begin
				next_st.flash_addr  = st.idx;
				next_st.flash_wdata = st.cfg[st.idx];
				next_st.flash_we    = 1'b1;
				if (st.idx == `GSRI_SLOT_LAST) begin
					next_st.state = gsri_pkg::GSRI_RUN;
				end else begin
					next_st.idx = st.idx + 2'h1;
				end
			end
			default: begin
				next_st.state = gsri_pkg::GSRI_RUN;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// register the whole state; sync chains reset to the idle pin levels
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			st                      <= '0;
			st.cs_sync              <= 3'h7;
			st.sclk_sync            <= 3'h7;
			st.state                <= gsri_pkg::GSRI_LOAD;
			st.cfg[`GSRI_SLOT_OFF]  <= `GSRI_RST_OFF;
			st.cfg[`GSRI_SLOT_SCL]  <= `GSRI_RST_SCL;
			st.cfg[`GSRI_SLOT_MISC] <= `GSRI_RST_MISC;
			st.cfg[`GSRI_SLOT_SMPL] <= `GSRI_RST_SMPL;
		end else begin
			st <= next_st;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs straight from the state flops
	assign spi_dout        = st.dout;
	assign spi_dout_oe     = st.dout_oe;
	assign flash_addr      = st.flash_addr;
	assign flash_wdata     = st.flash_wdata;
	assign flash_we        = st.flash_we;
	assign config_ready    = st.cfg_ready;
	assign bias_null_start = st.null_start;
	assign gyro_offset     = st.cfg[`GSRI_SLOT_OFF];
	assign gyro_scale      = st.cfg[`GSRI_SLOT_SCL];
	assign sample_period   = st.cfg[`GSRI_SLOT_SMPL];
	assign dio_out         = st.dio_out;
	assign dio_oe          = st.dio_oe;

endmodule

// ===== rtl/gsri_regs.svh
// gsri_regs.svh: register offsets, frame fields, reset values and timing
// assumes: included by the package and the design modules, no process here
`ifndef GSRI_REGS_SVH
`define GSRI_REGS_SVH

// byte addresses, low byte of each 16-bit register, then the word-address mask
`define GSRI_ADDR_RATE     7'h04
`define GSRI_ADDR_GYRO_OFF 7'h14
`define GSRI_ADDR_GYRO_SCL 7'h16
`define GSRI_ADDR_MISC     7'h34
`define GSRI_ADDR_SMPL     7'h36
`define GSRI_ADDR_GLOB     7'h3E
`define GSRI_ADDR_WORD     7'h7E

// frame layout: write flag, byte address, data byte
`define GSRI_WR_BIT        15
`define GSRI_ADR_HI        14
`define GSRI_ADR_LO        8
`define GSRI_LAST_BIT      5'h0F
`define GSRI_BITS_DONE     5'h10

// global command bits
`define GSRI_CMD_NULL      0
`define GSRI_CMD_SAVE      3

// misc control: data-ready line select, polarity, enable
`define GSRI_DR_SEL        0
`define GSRI_DR_POL        1
`define GSRI_DR_EN         2

// reset values of the flash-backed working registers
`define GSRI_RST_OFF       16'h0000
`define GSRI_RST_SCL       16'h0800
`define GSRI_RST_MISC      16'h0000
`define GSRI_RST_SMPL      16'h0001

// flash slots of the backed registers
`define GSRI_SLOT_OFF      2'h0
`define GSRI_SLOT_SCL      2'h1
`define GSRI_SLOT_MISC     2'h2
`define GSRI_SLOT_SMPL     2'h3
`define GSRI_SLOT_LAST     2'h3

// master-side timing, kept for reference by the bench
`define GSRI_REF_MHZ       200
`define GSRI_SCLK_MAX_KHZ  2500
`define GSRI_STALL_NS      9000
`define GSRI_STALL_CYC     ((`GSRI_STALL_NS * `GSRI_REF_MHZ) / 1000)

`endif

// ===== rtl/gsri_pkg.sv
// gsri_pkg: state types of the serial register interface
// assumes: gsri_regs.svh on the include path
`include "gsri_regs.svh"

package gsri_pkg;

	// configuration sequencer
	typedef enum logic [1:0] {
		GSRI_LOAD = 2'b00,
		GSRI_RUN  = 2'b01,
		GSRI_SAVE = 2'b10
	} gsri_cfg_type;

	// link-side receiver state
	typedef struct packed {
		logic [4:0]  count;
		logic [15:0] shift;
		logic [15:0] word;
		logic        done;
	} gsri_link_type;

	// core-side state
	typedef struct packed {
		logic [2:0]       cs_sync;
		logic [2:0]       sclk_sync;
		logic [2:0]       done_sync;
		logic [15:0]      resp;
		logic [15:0]      tx;
		logic             fall_seen;
		logic             dout;
		logic             dout_oe;
		logic [15:0]      rate;
		logic             drdy;
		logic [3:0][15:0] cfg;
		logic [1:0]       dio_out;
		logic [1:0]       dio_oe;
		gsri_cfg_type     state;
		logic [1:0]       idx;
		logic             phase;
		logic [1:0]       flash_addr;
		logic [15:0]      flash_wdata;
		logic             flash_we;
		logic             cfg_ready;
		logic             null_start;
	} gsri_core_type;

endpackage

// ===== rtl/gsri_frame_if.sv
// gsri_frame_if: one received frame handed from the link to the core
// assumes: word is stable whenever done is high
`timescale 1ns/1ps

interface gsri_frame_if;
	logic [15:0] word;
	logic        done;

	modport rx   (output word, output done);
	modport core (input word, input done);
endinterface

// ===== rtl/gsri_link_rx.sv
// gsri_link_rx: shift register on the master's serial clock
// assumes: chip select high between frames, link_rst held while clocks settle
`timescale 1ns/1ps
`include "gsri_regs.svh"

module gsri_link_rx (
	input  wire logic spi_sclk,
	input  wire logic spi_cs_n,
	input  wire logic spi_din,
	input  wire logic link_rst,
	gsri_frame_if.rx  frame
);

	gsri_pkg::gsri_link_type st;
	gsri_pkg::gsri_link_type next_st;

	////////////////////////////////////////////////////////////////////////
	// next state: msb first, extra clocks beyond sixteen are ignored
	always_comb begin
		next_st = st;
		if (st.count != `GSRI_BITS_DONE) begin
			next_st.shift = {st.shift[14:0], spi_din};
			next_st.count = st.count + 5'h01;
		end
		// done drops at the first edge of the next frame, so the core sees a level
		if (st.count == 5'h00) begin
			next_st.done = 1'b0;
		end
		if (st.count == `GSRI_LAST_BIT) begin
			next_st.word = {st.shift[14:0], spi_din};
			next_st.done = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// the serial clock stops between frames, so the count is cleared by chip select
	// counting only while selected
	always_ff @(posedge spi_sclk or posedge spi_cs_n or posedge link_rst) begin
		if (link_rst) begin
			st <= '0;
		end else if (spi_cs_n) begin
			st.count <= 5'h00;
		end else begin
			st <= next_st;
		end
	end

	assign frame.word = st.word;
	assign frame.done = st.done;

endmodule

// ===== verification/gsri_sva.sv
// gsri_sva: timing checks on the top-level pins of the register interface
// assumes: bound to gsri_top; all checks run on ref_clk
`timescale 1ns/1ps

module gsri_sva (
	input wire logic       ref_clk,
	input wire logic       sys_rst,
	input wire logic       spi_sclk,
	input wire logic       spi_cs_n,
	input wire logic       spi_dout,
	input wire logic       spi_dout_oe,
	input wire logic [1:0] flash_addr,
	input wire logic       flash_we,
	input wire logic       config_ready,
	input wire logic       bias_null_start
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	////////////////////////////////////////////////////////////////////////
	// link pins; deselect gets a few cycles of slack for the synchroniser
	property p_release; spi_cs_n [*5] |-> !spi_dout_oe; endproperty
	a_release: assert property (p_release) else $error("dout still driven");
	property p_msb_first; $fell(spi_cs_n) |-> ##[2:5] spi_dout_oe; endproperty
	a_msb_first: assert property (p_msb_first) else $error("msb not presented");
	property p_hold_rise; $rose(spi_sclk) && !spi_cs_n |=> $stable(spi_dout) [*4]; endproperty
	a_hold_rise: assert property (p_hold_rise) else $error("dout moved after rise");

	////////////////////////////////////////////////////////////////////////
	// commands and configuration sequencing
	property p_null_pulse; bias_null_start |=> !bias_null_start; endproperty
	a_null_pulse: assert property (p_null_pulse) else $error("null start too long");
	property p_save_walk;
		$rose(flash_we) |-> flash_addr == 2'h0 ##1 flash_we && flash_addr == 2'h1
			##1 flash_we && flash_addr == 2'h2 ##1 flash_we && flash_addr == 2'h3 ##1 !flash_we;
	endproperty
	a_save_walk: assert property (p_save_walk) else $error("bad flash save walk");
	property p_load_time; $fell(sys_rst) |-> !config_ready [*7] ##[1:3] config_ready; endproperty
	a_load_time: assert property (p_load_time) else $error("load time wrong");
	property p_ready_holds; config_ready |=> config_ready; endproperty
	a_ready_holds: assert property (p_ready_holds) else $error("ready dropped");
	property p_quiet_boot; !config_ready |-> !flash_we && !bias_null_start; endproperty
	a_quiet_boot: assert property (p_quiet_boot) else $error("action during load");
endmodule

// ===== verification/gsri_spi_master.sv
// gsri_spi_master: mode 3 master processor model on the serial link
// assumes: link_clk runs free; sclk only toggles inside frames
`timescale 1ns/1ps
`include "gsri_regs.svh"

module gsri_spi_master (
	input  wire logic link_clk,
	input  wire logic miso,
	output logic      sclk,
	output logic      cs_n,
	output logic      mosi
);
	initial begin
		sclk = 1'b1;
		cs_n = 1'b1;
		mosi = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// sixteen bit frame
	// sclk kept under limit
	// half of at least 17 link clocks keeps sclk near 2.45 MHz or slower
	task automatic xfer(input logic [15:0] tx, input int half, output logic [15:0] rx);
		@(posedge link_clk);
		cs_n <= 1'b0;
		for (int i = 15; i >= 0; i--) begin
			repeat (half) @(posedge link_clk);
			sclk <= 1'b0;
			mosi <= tx[i];
			repeat (half) @(posedge link_clk);
			sclk <= 1'b1;
			rx[i] = miso;
		end
		repeat (half) @(posedge link_clk);
		cs_n <= 1'b1;
		mosi <= ~mosi;
		repeat (`GSRI_STALL_NS / 12) @(posedge link_clk);
	endtask
endmodule

// ===== verification/tb_gyro_spi_register_interface.sv
// tb_gyro_spi_register_interface: model-based bench of the register interface
// assumes: flash answers combinationally; master model owns the link pins
`timescale 1ns/1ps

module tb_gyro_spi_register_interface;
	logic        ref_clk    = 1'b0;
	logic        link_clk   = 1'b0;
	logic        sys_rst    = 1'b1;
	logic [15:0] rate_in    = 16'h0000;
	logic        rate_valid = 1'b0;
	logic [15:0] flash_rdata, flash_wdata, gyro_offset, gyro_scale, sample_period;
	logic [1:0]  flash_addr, dio_out, dio_oe;
	logic        spi_sclk, spi_cs_n, spi_din, spi_dout, spi_dout_oe, miso;
	logic        flash_we, config_ready, bias_null_start;
	logic [15:0] flash_mem [4];
	logic [6:0]  amap [4] = '{7'h14, 7'h16, 7'h34, 7'h36};
	int          cfg [4];
	int          n_fail = 0, total_checks = 0, seed = 8, pend = -1, early = 0, rate_m, f0, r;

	always #2.5 ref_clk = ~ref_clk;
	always #6 link_clk = ~link_clk;
	// line pulled up while nobody drives it
	assign miso = spi_dout_oe ? spi_dout : 1'b1;
	assign flash_rdata = flash_mem[flash_addr];

	gsri_top i_dut (.ref_clk, .sys_rst, .spi_sclk, .spi_cs_n, .spi_din, .spi_dout,
		.spi_dout_oe, .rate_in, .rate_valid, .flash_rdata, .flash_addr, .flash_wdata,
		.flash_we, .config_ready, .bias_null_start, .gyro_offset, .gyro_scale,
		.sample_period, .dio_out, .dio_oe);
	gsri_spi_master i_mst (.link_clk, .miso, .sclk(spi_sclk), .cs_n(spi_cs_n), .mosi(spi_din));

	// flash array and null pulses seen while still selected
	always @(posedge ref_clk) begin
		if (flash_we === 1'b1) flash_mem[flash_addr] <= flash_wdata;
		if (bias_null_start === 1'b1 && !spi_cs_n) early <= early + 1;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic final_report();
		if (n_fail == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic check_cfg();
		check(gyro_offset, cfg[0]);
		check(gyro_scale, cfg[1]);
		check(sample_period, cfg[3]);
	endtask

	// release reset and wait for the flash load, bounded
	task automatic boot();
		int k;
		sys_rst <= 1'b0;
		pend = -1;
		k = 0;
		while (config_ready !== 1'b1 && k < 20) begin
			@(negedge ref_clk);
			k++;
		end
		if (k == 20) begin
			n_fail++;
			final_report();
		end
		for (int i = 0; i < 4; i++) cfg[i] = flash_mem[i];
		check_cfg();
	endtask

	// one frame at a random speed; the model predicts the next answer
	task automatic frame(input logic [15:0] tx);
		logic [15:0] rx;
		int          s;
		i_mst.xfer(tx, 17 + ($random(seed) & 3), rx);
		if (pend >= 0) check(rx, pend[15:0]);
		s = -1;
		for (int i = 0; i < 4; i++) if (amap[i] == {tx[14:9], 1'b0}) s = i;
		pend = -1;
		if (!tx[15]) begin
			pend = (s >= 0) ? cfg[s] : 0;
			if (tx[14:9] == 6'h02) pend = rate_m;
		end else if (s >= 0) begin
			cfg[s] = tx[8] ? {tx[7:0], cfg[s][7:0]} : {cfg[s][15:8], tx[7:0]};
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		for (int i = 0; i < 4; i++) flash_mem[i] = $random(seed);
		repeat (8) @(posedge ref_clk);
		check(gyro_scale, 16'h0800);
		check(sample_period, 16'h0001);
		boot();
		f0 = flash_mem[0];
		// byte writes, then read-only and reserved places
		for (int i = 0; i < 6; i++) begin
			r = $random(seed);
			frame({1'b1, amap[i % 4] | {6'h00, r[8]}, r[7:0]});
			check_cfg();
		end
		frame(16'h84A5);
		frame(16'hC05A);
		check_cfg();
		// pipelined reads at random byte addresses
		for (int i = 0; i < 4; i++) begin
			r = $random(seed);
			frame({1'b0, amap[i] | {6'h00, r[8]}, r[7:0]});
		end
		// data ready on line 0, active high, cleared by a rate read
		frame(16'hB406);
		@(posedge ref_clk);
		r = $random(seed);
		rate_in <= r[15:0];
		rate_valid <= 1'b1;
		rate_m = r & 16'hFFFF;
		@(posedge ref_clk);
		rate_valid <= 1'b0;
		repeat (3) @(negedge ref_clk);
		check(dio_out[0], 1'b1);
		check(dio_oe, 2'b01);
		frame(16'h0400);
		check(dio_out[0], 1'b0);
		frame(16'h0555);
		frame(16'h4000);
		frame(16'h0400);
		// null command acts before deselect and leaves flash alone
		r = early;
		frame(16'hBE01);
		check(early, r + 1);
		check(flash_mem[0], f0);
		frame(16'hBE08);
		for (int i = 0; i < 4; i++) check(flash_mem[i], cfg[i]);
		frame({1'b1, 7'h14, ~cfg[0][7:0]});
		check_cfg();
		// second reset reloads the saved words, not the later write
		@(posedge ref_clk);
		sys_rst <= 1'b1;
		repeat (4) @(posedge ref_clk);
		boot();
		final_report();
	end
endmodule

bind gsri_top gsri_sva i_sva (.ref_clk, .sys_rst, .spi_sclk, .spi_cs_n, .spi_dout,
	.spi_dout_oe, .flash_addr, .flash_we, .config_ready, .bias_null_start);
